// File: hdl/cpu_register_file_alu.sv
// CPU datapath: register file, ALU, status, prefetch, stack and I/O map
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_alu (
  input  wire logic                 clock_i,
  input  wire logic                 rstn_i,
  input  wire core_pkg::exec_req_t  exec_i,
  input  wire core_pkg::flow_req_t  flow_i,
  input  wire core_pkg::data_req_t  data_i,
  input  wire logic [15:0]          fetch_word_i,
  input  wire logic                 fetch_valid_i,
  input  wire logic                 fetch_second_i,
  input  wire logic                 hold_i,
  input  wire logic [7:0]           irq_req_i,
  input  wire logic [7:0]           io_rdata_i,
  input  wire logic [7:0]           mem_rdata_i,
  output logic [15:0]               fetch_addr_o,
  output logic [31:0]               instr_o,
  output logic                      instr_valid_o,
  output logic [7:0]                result_o,
  output logic [7:0]                status_o,
  output logic [15:0]               stack_top_pointer_o,
  output logic [15:0]               pointer_a_o,
  output logic [15:0]               pointer_b_o,
  output logic [15:0]               pointer_c_o,
  output logic [15:0]               table_addr_o,
  output logic [15:0]               rd_pair_o,
  output core_pkg::data_bus_t       bus_o,
  output logic [7:0]                read_data_o,
  output logic                      irq_taken_o,
  output logic [2:0]                irq_index_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [core_pkg::REG_COUNT-1:0][7:0] regs;
    logic [7:0]                          status;
    logic [15:0]                         stack;
    logic [15:0]                         counter;
    logic [15:0]                         first_word;
    logic [31:0]                         instr;
    logic                                instr_valid;
    logic [7:0]                          result;
    logic [15:0]                         rd_pair;
    core_pkg::data_bus_t                 bus;
    logic [7:0]                          read_data;
    logic                                irq_taken;
    logic [2:0]                          irq_index;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [3:0]         rd_idx;
  logic [3:0]         rr_idx;
  logic [7:0]         op_a;
  logic [7:0]         op_b;
  core_pkg::alu_out_t alu_out;
  logic               irq_any;
  logic [2:0]         irq_pick;
  logic [15:0]        io_addr;

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  assign rd_idx = exec_i.rd[3:0] ^ core_pkg::REG_BASE[3:0];
  assign rr_idx = exec_i.rr[3:0] ^ core_pkg::REG_BASE[3:0];
  assign op_a   = st_ff.regs[rd_idx];
  assign op_b   = (exec_i.src == core_pkg::SRC_IMM) ? exec_i.imm
                : st_ff.regs[rr_idx];
  assign io_addr = {8'h00, data_i.addr[7:0]};

  alu_unit u_alu (
    .op_i      (exec_i.op),
    .a_i       (op_a),
    .b_i       (op_b),
    .bit_sel_i (exec_i.bit_sel),
    .flags_i   (st_ff.status),
    .out_o     (alu_out)
  );

  // Lowest index is the lowest vector address
  always_comb begin
    irq_pick = 3'h0;
    irq_any  = 1'b0;
    for (int i = int'(core_pkg::NUM_IRQ) - 1; i >= 0; i--) begin
      if (irq_req_i[i]) begin
        irq_pick = 3'(i);
        irq_any  = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.irq_taken   = 1'b0;
    nxt_st.bus.rd      = 1'b0;
    nxt_st.bus.wr      = 1'b0;
    nxt_st.bus.io_sel  = 1'b0;
    nxt_st.bus.mem_sel = 1'b0;

    // Prefetch stage
    if (!hold_i && fetch_valid_i) begin
      nxt_st.counter = st_ff.counter + core_pkg::COUNT_STEP;
      if (fetch_second_i) begin
        nxt_st.instr       = {st_ff.first_word, fetch_word_i};
        nxt_st.instr_valid = 1'b1;
      end else begin
        nxt_st.first_word  = fetch_word_i;
        nxt_st.instr       = {16'h0000, fetch_word_i};
        nxt_st.instr_valid = 1'b1;
      end
    end else if (!hold_i) begin
      nxt_st.instr_valid = 1'b0;
    end

    // Execute stage
    if (exec_i.valid && exec_i.rd[4]) begin
      if (exec_i.wide) begin
        nxt_st.rd_pair = {st_ff.regs[rd_idx | 4'h1],
                          st_ff.regs[rd_idx & 4'hE]};
        if (exec_i.wr_en) begin
          nxt_st.regs[rd_idx & 4'hE] = exec_i.wide_data[7:0];
          nxt_st.regs[rd_idx | 4'h1] = exec_i.wide_data[15:8];
        end
      end else begin
        nxt_st.result = alu_out.result;
        if (exec_i.wr_en) begin
          nxt_st.regs[rd_idx] = alu_out.result;
        end
        if (exec_i.flags_en) begin
          nxt_st.status = alu_out.flags;
        end
      end
    end

    // Data space access, I/O window first
    if (data_i.rd || data_i.wr) begin
      nxt_st.bus.addr  = data_i.addr;
      nxt_st.bus.wdata = data_i.wdata;
      nxt_st.bus.rd    = data_i.rd;
      nxt_st.bus.wr    = data_i.wr;
      if (data_i.addr <= {8'h00, core_pkg::IO_LAST}) begin
        nxt_st.bus.io_sel = 1'b1;
        case (io_addr[7:0])
          core_pkg::IO_STACK_LO: begin
            nxt_st.read_data = st_ff.stack[7:0];
            if (data_i.wr) begin
              nxt_st.stack[7:0] = data_i.wdata;
            end
          end
          core_pkg::IO_STACK_HI: begin
            nxt_st.read_data = st_ff.stack[15:8];
            if (data_i.wr) begin
              nxt_st.stack[15:8] = data_i.wdata;
            end
          end
          core_pkg::IO_STATUS: begin
            nxt_st.read_data = st_ff.status;
            if (data_i.wr) begin
              nxt_st.status = data_i.wdata;
            end
          end
          default: nxt_st.read_data = io_rdata_i;
        endcase
      end else begin
        nxt_st.bus.mem_sel = 1'b1;
        nxt_st.read_data   = mem_rdata_i;
      end
    end

    // Stack and flow control
    if (flow_i.call) begin
      nxt_st.stack   = st_ff.stack - core_pkg::RET_STEP;
      nxt_st.counter = flow_i.target;
      // Low byte of the return counter goes to the old stack top
      nxt_st.bus.addr    = st_ff.stack;
      nxt_st.bus.wdata   = st_ff.counter[7:0];
      nxt_st.bus.rd      = 1'b0;
      nxt_st.bus.wr      = 1'b1;
      nxt_st.bus.mem_sel = 1'b1;
      nxt_st.bus.io_sel  = 1'b0;
    end else if (flow_i.ret || flow_i.reti) begin
      nxt_st.stack   = st_ff.stack + core_pkg::RET_STEP;
      nxt_st.counter = flow_i.target;
      if (flow_i.reti) begin
        nxt_st.status[core_pkg::FLAG_I] = 1'b1;
      end
    end else if (flow_i.push) begin
      nxt_st.stack = st_ff.stack - core_pkg::BYTE_STEP;
    end else if (flow_i.pop) begin
      nxt_st.stack = st_ff.stack + core_pkg::BYTE_STEP;
    end else if (flow_i.jump) begin
      nxt_st.counter = flow_i.target;
    end

    // Interrupt entry pushes the return counter low byte and clears global enable
    if (irq_any && st_ff.status[core_pkg::FLAG_I] && !flow_i.call &&
        !flow_i.ret && !flow_i.reti) begin
      nxt_st.irq_taken   = 1'b1;
      nxt_st.irq_index   = irq_pick;
      nxt_st.stack       = st_ff.stack - core_pkg::RET_STEP;
      nxt_st.bus.addr    = st_ff.stack;
      nxt_st.bus.wdata   = st_ff.counter[7:0];
      nxt_st.bus.wr      = 1'b1;
      nxt_st.bus.mem_sel = 1'b1;
      nxt_st.bus.io_sel  = 1'b0;
      nxt_st.bus.rd      = 1'b0;
      nxt_st.counter     = {13'h0000, irq_pick} + core_pkg::COUNT_STEP;
      nxt_st.status[core_pkg::FLAG_I] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff         <= '0;
      st_ff.status  <= core_pkg::STATUS_RESET;
      st_ff.stack   <= core_pkg::STACK_RESET;
      st_ff.counter <= core_pkg::COUNT_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign fetch_addr_o        = st_ff.counter;
  assign instr_o             = st_ff.instr;
  assign instr_valid_o       = st_ff.instr_valid;
  assign result_o            = st_ff.result;
  assign status_o            = st_ff.status;
  assign stack_top_pointer_o = st_ff.stack;
  assign pointer_a_o = {st_ff.regs[core_pkg::PTR_A_IDX + 4'h1],
                        st_ff.regs[core_pkg::PTR_A_IDX]};
  assign pointer_b_o = {st_ff.regs[core_pkg::PTR_B_IDX + 4'h1],
                        st_ff.regs[core_pkg::PTR_B_IDX]};
  assign pointer_c_o = {st_ff.regs[core_pkg::PTR_C_IDX + 4'h1],
                        st_ff.regs[core_pkg::PTR_C_IDX]};
  assign table_addr_o = {st_ff.regs[core_pkg::PTR_C_IDX + 4'h1],
                         st_ff.regs[core_pkg::PTR_C_IDX]};
  assign rd_pair_o   = st_ff.rd_pair;
  assign bus_o       = st_ff.bus;
  assign read_data_o = st_ff.read_data;
  assign irq_taken_o = st_ff.irq_taken;
  assign irq_index_o = st_ff.irq_index;

endmodule
`default_nettype wire

// File: hdl/core_pkg.sv
// Shared types and constants for the CPU datapath core
package core_pkg;

  localparam int unsigned REG_COUNT      = 16;
  localparam logic [4:0]  REG_BASE       = 5'h10;
  localparam logic [3:0]  PTR_A_IDX      = 4'hA;
  localparam logic [3:0]  PTR_B_IDX      = 4'hC;
  localparam logic [3:0]  PTR_C_IDX      = 4'hE;
  localparam logic [7:0]  IO_LAST        = 8'h3F;
  localparam logic [7:0]  IO_STACK_LO    = 8'h3D;
  localparam logic [7:0]  IO_STACK_HI    = 8'h3E;
  localparam logic [7:0]  IO_STATUS      = 8'h3F;
  localparam logic [15:0] STACK_RESET    = 16'h005F;
  localparam logic [15:0] RET_STEP       = 16'h0002;
  localparam logic [15:0] BYTE_STEP      = 16'h0001;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_STEP     = 16'h0001;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam int unsigned NUM_IRQ        = 8;

  // Status flag positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
    ALU_MOV, ALU_COM, ALU_NEG, ALU_INC, ALU_DEC, ALU_LSR, ALU_ASR,
    ALU_SWAP, ALU_BST
  } alu_op_t;

  typedef enum logic [1:0] {
    SRC_REG, SRC_IMM
  } src_sel_t;

  // Decoded operation from the instruction decoder
  typedef struct packed {
    logic       valid;
    alu_op_t    op;
    logic [4:0] rd;
    logic [4:0] rr;
    src_sel_t   src;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic       wr_en;
    logic       wide;
    logic [15:0] wide_data;
    logic       flags_en;
  } exec_req_t;

  // Stack and flow control request
  typedef struct packed {
    logic        call;
    logic        irq_entry;
    logic        ret;
    logic        reti;
    logic        push;
    logic        pop;
    logic        jump;
    logic [15:0] target;
  } flow_req_t;

  // Data space access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } data_req_t;

  typedef struct packed {
    logic        io_sel;
    logic        mem_sel;
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } data_bus_t;

  typedef struct packed {
    logic [7:0] result;
    logic [7:0] flags;
  } alu_out_t;

endpackage

// File: hdl/alu_unit.sv
// Single-cycle arithmetic, logic and bit unit
`timescale 1ns/1ps
`default_nettype none
module alu_unit (
  input  wire core_pkg::alu_op_t op_i,
  input  wire logic [7:0]        a_i,
  input  wire logic [7:0]        b_i,
  input  wire logic [2:0]        bit_sel_i,
  input  wire logic [7:0]        flags_i,
  output core_pkg::alu_out_t     out_o
);
  logic [8:0] sum;
  logic       cin;
  logic       sub;
  logic [7:0] r;
  logic [7:0] f;

  always_comb begin
    cin = flags_i[core_pkg::FLAG_C];
    sub = 1'b0;
    sum = 9'h000;
    r   = a_i;
    f   = flags_i;
    case (op_i)
      core_pkg::ALU_ADD: sum = {1'b0, a_i} + {1'b0, b_i};
      core_pkg::ALU_ADC: sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
      core_pkg::ALU_SUB: begin
        sub = 1'b1;
        sum = {1'b0, a_i} - {1'b0, b_i};
      end
      core_pkg::ALU_SBC: begin
        sub = 1'b1;
        sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
      end
      core_pkg::ALU_INC: sum = {1'b0, a_i} + 9'h001;
      core_pkg::ALU_DEC: sum = {1'b0, a_i} - 9'h001;
      core_pkg::ALU_NEG: begin
        sub = 1'b1;
        sum = 9'h000 - {1'b0, a_i};
      end
      default: sum = 9'h000;
    endcase
    case (op_i)
      core_pkg::ALU_ADD, core_pkg::ALU_ADC, core_pkg::ALU_SUB,
      core_pkg::ALU_SBC, core_pkg::ALU_NEG: begin
        r = sum[7:0];
        f[core_pkg::FLAG_C] = sum[8];
        f[core_pkg::FLAG_H] = sub ? (a_i[3:0] < b_i[3:0])
                                  : (sum[4] ^ a_i[4] ^ b_i[4]);
        f[core_pkg::FLAG_V] = sub ? ((a_i[7] ^ b_i[7]) & (a_i[7] ^ r[7]))
                                  : (~(a_i[7] ^ b_i[7]) & (a_i[7] ^ r[7]));
      end
      core_pkg::ALU_INC, core_pkg::ALU_DEC: begin
        r = sum[7:0];
        f[core_pkg::FLAG_V] = (op_i == core_pkg::ALU_INC) ?
                              (r == 8'h80) : (r == 8'h7F);
      end
      core_pkg::ALU_AND: begin
        r = a_i & b_i;
        f[core_pkg::FLAG_V] = 1'b0;
      end
      core_pkg::ALU_OR: begin
        r = a_i | b_i;
        f[core_pkg::FLAG_V] = 1'b0;
      end
      core_pkg::ALU_XOR: begin
        r = a_i ^ b_i;
        f[core_pkg::FLAG_V] = 1'b0;
      end
      core_pkg::ALU_COM: begin
        r = ~a_i;
        f[core_pkg::FLAG_C] = 1'b1;
        f[core_pkg::FLAG_V] = 1'b0;
      end
      core_pkg::ALU_MOV: r = b_i;
      core_pkg::ALU_LSR, core_pkg::ALU_ASR: begin
        r = {(op_i == core_pkg::ALU_ASR) & a_i[7], a_i[7:1]};
        f[core_pkg::FLAG_C] = a_i[0];
        f[core_pkg::FLAG_V] = r[7] ^ a_i[0];
      end
      core_pkg::ALU_SWAP: r = {a_i[3:0], a_i[7:4]};
      core_pkg::ALU_BST: f[core_pkg::FLAG_T] = a_i[bit_sel_i];
      default: r = a_i;
    endcase
    if (op_i != core_pkg::ALU_BST && op_i != core_pkg::ALU_MOV &&
        op_i != core_pkg::ALU_SWAP) begin
      f[core_pkg::FLAG_Z] = (r == 8'h00);
      f[core_pkg::FLAG_N] = r[7];
      f[core_pkg::FLAG_S] = r[7] ^ f[core_pkg::FLAG_V];
    end
    out_o.result = r;
    out_o.flags  = f;
  end
endmodule
`default_nettype wire

// File: tb/cpu_core_asserts.sv
// Concurrent checks on the ports of the CPU datapath core
`timescale 1ns/1ps
`default_nettype none
module cpu_core_asserts (
  input wire logic                clock_i,
  input wire logic                rstn_i,
  input wire core_pkg::exec_req_t exec_i,
  input wire core_pkg::flow_req_t flow_i,
  input wire core_pkg::data_req_t data_i,
  input wire logic [7:0]          irq_req_i,
  input wire logic [7:0]          result_o,
  input wire logic [7:0]          status_o,
  input wire logic [15:0]         stack_top_pointer_o,
  input wire logic [15:0]         pointer_a_o,
  input wire logic [15:0]         pointer_c_o,
  input wire logic [15:0]         table_addr_o,
  input wire core_pkg::data_bus_t bus_o,
  input wire logic                irq_taken_o,
  input wire logic [2:0]          irq_index_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // Lowest pending request number
  logic [2:0] low_idx;
  always_comb begin
    low_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (irq_req_i[i]) begin
        low_idx = 3'(i);
      end
    end
  end

  sequence s_quiet;
    !(flow_i.call || flow_i.ret || flow_i.reti || flow_i.push ||
      flow_i.pop) && irq_req_i == 8'h00;
  endsequence
  sequence s_load;
    exec_i.valid && exec_i.wr_en && exec_i.rd[4] && !exec_i.wide &&
    exec_i.op == core_pkg::ALU_MOV && exec_i.src == core_pkg::SRC_IMM;
  endsequence
  sequence s_copy;
    exec_i.valid && exec_i.wr_en && exec_i.rd[4] && !exec_i.wide &&
    exec_i.op == core_pkg::ALU_MOV && exec_i.src == core_pkg::SRC_REG &&
    exec_i.rr == $past(exec_i.rd);
  endsequence
  sequence s_entry;
    irq_taken_o && !$past(data_i.wr) && !$past(exec_i.flags_en);
  endsequence

  property p_fwd;
    s_load ##1 s_copy |=> result_o == $past(exec_i.imm, 2);
  endproperty
  property p_low;
    exec_i.valid && !exec_i.rd[4] |=> $stable(result_o);
  endproperty
  property p_wide;
    exec_i.valid && exec_i.wide && exec_i.wr_en && exec_i.rd[4:1] == 4'hD
    |=> pointer_a_o == $past(exec_i.wide_data);
  endproperty
  property p_table;
    table_addr_o == pointer_c_o;
  endproperty
  property p_call;
    flow_i.call && !data_i.wr |=>
    stack_top_pointer_o == $past(stack_top_pointer_o) - 16'h0002 &&
    bus_o.wr && bus_o.mem_sel && bus_o.addr == $past(stack_top_pointer_o);
  endproperty
  property p_ret;
    (flow_i.ret || flow_i.reti) && !data_i.wr |=>
    stack_top_pointer_o == $past(stack_top_pointer_o) + 16'h0002;
  endproperty
  property p_stack_io;
    data_i.wr && data_i.addr == 16'h003D ##0 s_quiet |=>
    stack_top_pointer_o[7:0] == $past(data_i.wdata);
  endproperty
  property p_io;
    data_i.wr ##0 s_quiet |=> bus_o.wr && bus_o.mem_sel == !bus_o.io_sel &&
    bus_o.io_sel == ($past(data_i.addr) <= 16'h003F);
  endproperty
  property p_gate;
    irq_taken_o |-> $past(status_o[7]) && $past(irq_req_i) != 8'h00;
  endproperty
  property p_prio;
    irq_taken_o |-> irq_index_o == $past(low_idx);
  endproperty
  property p_entry;
    s_entry |-> !status_o[7] && status_o[6:0] == $past(status_o[6:0]) &&
    stack_top_pointer_o == $past(stack_top_pointer_o) - 16'h0002;
  endproperty

  a_fwd: assert property (p_fwd)
    else $error("operand missed previous write");
  a_low: assert property (p_low)
    else $error("low register number acted on");
  a_wide: assert property (p_wide)
    else $error("pair write wrong");
  a_table: assert property (p_table)
    else $error("table pointer differs");
  a_call: assert property (p_call)
    else $error("call step wrong");
  a_ret: assert property (p_ret)
    else $error("return step wrong");
  a_stack_io: assert property (p_stack_io)
    else $error("stack low byte write lost");
  a_io: assert property (p_io)
    else $error("space select wrong");
  a_gate: assert property (p_gate)
    else $error("interrupt taken while gated");
  a_prio: assert property (p_prio)
    else $error("interrupt order wrong");
  a_entry: assert property (p_entry)
    else $error("entry state wrong");
endmodule

bind cpu_register_file_alu cpu_core_asserts i_chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .exec_i(exec_i), .flow_i(flow_i),
  .data_i(data_i), .irq_req_i(irq_req_i), .result_o(result_o),
  .status_o(status_o), .stack_top_pointer_o(stack_top_pointer_o),
  .pointer_a_o(pointer_a_o), .pointer_c_o(pointer_c_o),
  .table_addr_o(table_addr_o), .bus_o(bus_o), .irq_taken_o(irq_taken_o),
  .irq_index_o(irq_index_o)
);
`default_nettype wire

// File: tb/cpu_far_side_model.sv
// Program and data memory model beyond the core
`timescale 1ns/1ps
`default_nettype none
module cpu_far_side_model (
  input  wire logic                clock_i,
  input  wire logic [15:0]         fetch_addr_i,
  input  wire core_pkg::data_bus_t bus_i,
  output logic [15:0]              fetch_word_o,
  output logic [7:0]               io_rdata_o,
  output logic [7:0]               mem_rdata_o
);
  logic [7:0] mem [256];
  logic [7:0] churn_ff = 8'h00;
  always_ff @(posedge clock_i) begin
    churn_ff <= churn_ff + 8'h35;
    if (bus_i.wr && bus_i.mem_sel) begin
      mem[bus_i.addr[7:0]] <= bus_i.wdata;
    end
  end
  // Idle read lines change every cycle
  assign mem_rdata_o = (bus_i.rd && bus_i.mem_sel) ?
                       mem[bus_i.addr[7:0]] : churn_ff;
  assign io_rdata_o = (bus_i.rd && bus_i.io_sel) ?
                      ~bus_i.addr[7:0] : ~churn_ff;
  assign fetch_word_o = {8'hA5, fetch_addr_i[7:0]};
endmodule
`default_nettype wire

// File: tb/cpu_register_file_alu_tb.sv
// Self-checking bench for the CPU datapath core
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_alu_tb;
  logic                clock_i = 1'b0;
  logic                rstn_i = 1'b0;
  core_pkg::exec_req_t exec_i;
  core_pkg::flow_req_t flow_i;
  core_pkg::data_req_t data_i;
  logic [15:0]         fetch_word_i;
  logic                fetch_valid_i;
  logic                fetch_second_i;
  logic                hold_i;
  logic [7:0]          irq_req_i;
  logic [7:0]          io_rdata_i;
  logic [7:0]          mem_rdata_i;
  logic [15:0]         fetch_addr_o;
  logic [31:0]         instr_o;
  logic                instr_valid_o;
  logic [7:0]          result_o;
  logic [7:0]          status_o;
  logic [15:0]         stack_top_pointer_o;
  logic [15:0]         pointer_a_o;
  logic [15:0]         pointer_b_o;
  logic [15:0]         pointer_c_o;
  logic [15:0]         table_addr_o;
  logic [15:0]         rd_pair_o;
  core_pkg::data_bus_t bus_o;
  logic [7:0]          read_data_o;
  logic                irq_taken_o;
  logic [2:0]          irq_index_o;
  int                  err_total = 0;
  int                  checks_done = 0;
  int                  cyc = 0;

  initial forever #2.5 clock_i = ~clock_i;

  cpu_register_file_alu i_dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .exec_i(exec_i), .flow_i(flow_i),
    .data_i(data_i), .fetch_word_i(fetch_word_i),
    .fetch_valid_i(fetch_valid_i), .fetch_second_i(fetch_second_i),
    .hold_i(hold_i), .irq_req_i(irq_req_i), .io_rdata_i(io_rdata_i),
    .mem_rdata_i(mem_rdata_i), .fetch_addr_o(fetch_addr_o),
    .instr_o(instr_o), .instr_valid_o(instr_valid_o), .result_o(result_o),
    .status_o(status_o), .stack_top_pointer_o(stack_top_pointer_o),
    .pointer_a_o(pointer_a_o), .pointer_b_o(pointer_b_o),
    .pointer_c_o(pointer_c_o), .table_addr_o(table_addr_o),
    .rd_pair_o(rd_pair_o),
    .bus_o(bus_o), .read_data_o(read_data_o), .irq_taken_o(irq_taken_o),
    .irq_index_o(irq_index_o)
  );
  cpu_far_side_model i_far (
    .clock_i(clock_i), .fetch_addr_i(fetch_addr_o), .bus_i(bus_o),
    .fetch_word_o(fetch_word_i), .io_rdata_o(io_rdata_i),
    .mem_rdata_o(mem_rdata_i)
  );

  // ----------------------------------------
  // Drivers and checking
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask
  task automatic go(input core_pkg::exec_req_t e,
                    input core_pkg::flow_req_t f,
                    input core_pkg::data_req_t d);
    exec_i = e;
    flow_i = f;
    data_i = d;
    @(negedge clock_i);
  endtask
  task automatic ex(input core_pkg::alu_op_t op, input logic [4:0] rd,
                    input logic [4:0] rr, input logic im,
                    input logic [7:0] imm, input logic fl);
    go('{valid: 1'b1, op: op, rd: rd, rr: rr, imm: imm, wr_en: 1'b1,
         src: im ? core_pkg::SRC_IMM : core_pkg::SRC_REG, flags_en: fl,
         default: '0}, '0, '0);
  endtask
  task automatic dacc(input logic wr, input logic [15:0] a,
                      input logic [7:0] d);
    go('0, '0, '{rd: !wr, wr: wr, addr: a, wdata: d});
  endtask
  task automatic fl(input logic [6:0] kind);
    go('0, {kind, 16'h0000}, '0);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    go('0, '0, '0);
    while (irq_taken_o !== 1'b1 && n < 4) begin
      go('0, '0, '0);
      n++;
    end
    cmp(irq_taken_o, 1'b1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fetch();
    fetch_valid_i = 1'b1;
    @(negedge clock_i);
    cmp({instr_valid_o, instr_o}, {1'b1, 32'h0000_A500});
    cmp(fetch_addr_o, 16'h0001);
    @(negedge clock_i);
    fetch_second_i = 1'b1;
    @(negedge clock_i);
    cmp({instr_valid_o, instr_o}, {1'b1, 32'hA501_A502});
    fetch_second_i = 1'b0;
    hold_i = 1'b1;
    @(negedge clock_i);
    cmp(fetch_addr_o, 16'h0003);
    fetch_valid_i = 1'b0;
    hold_i = 1'b0;
    $display("fetch test done");
  endtask
  task automatic t_alu();
    ex(core_pkg::ALU_MOV, 5'h10, 5'h10, 1'b1, 8'h7F, 1'b0);
    ex(core_pkg::ALU_ADD, 5'h10, 5'h10, 1'b1, 8'h01, 1'b1);
    cmp({result_o, status_o}, 16'h802C);
    ex(core_pkg::ALU_MOV, 5'h11, 5'h10, 1'b0, 8'h00, 1'b0);
    cmp(result_o, 8'h80);
    ex(core_pkg::ALU_SUB, 5'h10, 5'h10, 1'b1, 8'h80, 1'b1);
    cmp({result_o, status_o}, 16'h0002);
    ex(core_pkg::ALU_INC, 5'h11, 5'h11, 1'b0, 8'h00, 1'b0);
    cmp(result_o, 8'h81);
    ex(core_pkg::ALU_AND, 5'h11, 5'h11, 1'b1, 8'h0F, 1'b0);
    cmp(result_o, 8'h01);
    ex(core_pkg::ALU_SWAP, 5'h11, 5'h11, 1'b0, 8'h00, 1'b0);
    cmp(result_o, 8'h10);
    ex(core_pkg::ALU_ADD, 5'h05, 5'h05, 1'b1, 8'h33, 1'b0);
    cmp(result_o, 8'h10);
    $display("alu test done");
  endtask
  task automatic t_ptr();
    for (int i = 0; i < 3; i++) begin
      go('{valid: 1'b1, op: core_pkg::ALU_MOV, src: core_pkg::SRC_REG,
           rd: 5'h1A + 5'(2 * i), wr_en: 1'b1, wide: 1'b1,
           wide_data: 16'h1234 + 16'(i) * 16'h1111, default: '0}, '0, '0);
    end
    cmp({pointer_a_o, pointer_b_o}, 32'h1234_2345);
    cmp({pointer_c_o, table_addr_o}, 32'h3456_3456);
    go('{valid: 1'b1, op: core_pkg::ALU_MOV, src: core_pkg::SRC_REG,
         rd: 5'h1C, wide: 1'b1, default: '0}, '0, '0);
    cmp(rd_pair_o, 16'h2345);
    ex(core_pkg::ALU_MOV, 5'h1B, 5'h1B, 1'b1, 8'hAB, 1'b0);
    cmp(pointer_a_o, 16'hAB34);
    ex(core_pkg::ALU_MOV, 5'h12, 5'h1B, 1'b0, 8'h00, 1'b0);
    cmp(result_o, 8'hAB);
    $display("pointer test done");
  endtask
  task automatic t_stack();
    dacc(1'b1, 16'h003D, 8'h50);
    cmp({bus_o.io_sel, bus_o.wr}, 2'h3);
    dacc(1'b1, 16'h003E, 8'h00);
    cmp(stack_top_pointer_o, 16'h0050);
    fl(7'h40);
    cmp(stack_top_pointer_o, 16'h004E);
    cmp({bus_o.wr, bus_o.mem_sel, bus_o.addr}, {2'h3, 16'h0050});
    fl(7'h04);
    cmp(stack_top_pointer_o, 16'h004D);
    fl(7'h02);
    cmp(stack_top_pointer_o, 16'h004E);
    fl(7'h10);
    cmp(stack_top_pointer_o, 16'h0050);
    dacc(1'b1, 16'h0100, 8'h5A);
    cmp({bus_o.io_sel, bus_o.mem_sel, bus_o.addr}, {2'h1, 16'h0100});
    dacc(1'b0, 16'h003F, 8'h00);
    cmp(read_data_o, 8'h02);
    dacc(1'b0, 16'h003D, 8'h00);
    cmp(read_data_o, 8'h50);
    $display("stack test done");
  endtask
  task automatic t_irq();
    dacc(1'b1, 16'h003F, 8'hC1);
    irq_req_i = 8'h06;
    wait_irq();
    cmp(irq_index_o, 3'h1);
    cmp({stack_top_pointer_o, status_o}, {16'h004E, 8'h41});
    go('0, '0, '0);
    cmp(irq_taken_o, 1'b0);
    irq_req_i = 8'h00;
    fl(7'h08);
    cmp({stack_top_pointer_o, status_o}, {16'h0050, 8'hC1});
    irq_req_i = 8'h80;
    wait_irq();
    cmp(irq_index_o, 3'h7);
    irq_req_i = 8'h00;
    go('0, '0, '0);
    $display("interrupt test done");
  endtask

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      results();
    end
  end

  initial begin
    exec_i = '0;
    flow_i = '0;
    data_i = '0;
    fetch_valid_i = 1'b0;
    fetch_second_i = 1'b0;
    hold_i = 1'b0;
    irq_req_i = 8'h00;
    repeat (10) @(negedge clock_i);
    rstn_i = 1'b1;
    cmp(stack_top_pointer_o, core_pkg::STACK_RESET);
    cmp(status_o, core_pkg::STATUS_RESET);
    t_fetch();
    t_alu();
    t_ptr();
    t_stack();
    t_irq();
    results();
  end
endmodule
`default_nettype wire
